// *** esc_pkg.sv ***
// Purpose: Shared constants and carrier types for the MAC statistics counter bank.
// Assumes: One clock domain; counters are reached over a plain strobe register port.
// Notes:   Offsets are byte addresses on a 32-bit data port.
`default_nettype none

package esc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [31:0] OFS_NET_CTRL = 32'hf802c000; // Control word
	localparam logic [31:0] OFS_NET_CFG = 32'hf802c004; // Configuration word
	localparam logic [31:0] OFS_PAUSE = 32'hf802c03c; // Good pause frames
	localparam logic [31:0] OFS_TX_OK = 32'hf802c040; // Frames sent
	localparam logic [31:0] OFS_SCOL = 32'hf802c044; // One collision
	localparam logic [31:0] OFS_MCOL = 32'hf802c048; // Two to fifteen collisions
	localparam logic [31:0] OFS_RX_OK = 32'hf802c04c; // Good frames kept
	localparam logic [31:0] OFS_CRC = 32'hf802c050; // Bad check sequence
	localparam logic [31:0] OFS_ALIGN = 32'hf802c054; // Odd bit count
	localparam logic [31:0] OFS_DEFER = 32'hf802c058; // Deferred sends
	localparam logic [31:0] OFS_LATE = 32'hf802c05c; // Late collisions
	localparam logic [31:0] OFS_TOO_MANY_HITS_FIELD = 32'hf802c060; // Abandoned sends

	// ----------------------------------------------------------------
	// Control and configuration fields
	// ----------------------------------------------------------------
	localparam int NCR_RX_EN_BIT = 2; // Receive enable
	localparam int NCR_STAT_WE_BIT = 7; // Counter write enable
	localparam int NCFG_BIG_FRAME_BIT = 8; // Accept 1536-byte frames
	localparam logic [31:0] NCR_RESET = 32'h00000000;
	localparam logic [31:0] NCFG_RESET = 32'h00000000;
	localparam logic [31:0] NCR_MASK = 32'h00000084; // Implemented bits
	localparam logic [31:0] NCFG_MASK = 32'h00000100; // Implemented bits

	// ----------------------------------------------------------------
	// Frame and collision limits
	// ----------------------------------------------------------------
	localparam logic [15:0] FRAME_MIN_LEN = 16'h0040; // 64 bytes
	localparam logic [15:0] FRAME_MAX_LEN = 16'h05ee; // 1518 bytes
	localparam logic [15:0] FRAME_MAX_BIG = 16'h0600; // 1536 bytes
	localparam logic [4:0] COL_NONE = 5'h00;
	localparam logic [4:0] COL_ONE = 5'h01;
	localparam logic [4:0] COL_MULTI_MIN = 5'h02;
	localparam logic [4:0] COL_MULTI_MAX = 5'h0f; // Fifteen
	localparam logic [4:0] COL_EXCESS = 5'h10; // Sixteen: send abandoned

	// ----------------------------------------------------------------
	// Counter bank layout
	// ----------------------------------------------------------------
	localparam int NUM_CNT = 10;
	localparam int CNT_MAX_W = 24;
	localparam logic [23:0] CNT_RESET = 24'h000000;
	localparam int IDX_PAUSE = 0;
	localparam int IDX_TX_OK = 1;
	localparam int IDX_SCOL = 2;
	localparam int IDX_MCOL = 3;
	localparam int IDX_RX_OK = 4;
	localparam int IDX_CRC = 5;
	localparam int IDX_ALIGN = 6;
	localparam int IDX_DEFER = 7;
	localparam int IDX_LATE = 8;
	localparam int IDX_TOO_MANY_HITS_FIELD = 9;
	localparam int CNT_W [NUM_CNT] = '{16, 24, 16, 16, 24, 8, 8, 16, 8, 8};
	localparam logic [31:0] CNT_OFS [NUM_CNT] = '{OFS_PAUSE, OFS_TX_OK, OFS_SCOL,
		OFS_MCOL, OFS_RX_OK, OFS_CRC, OFS_ALIGN, OFS_DEFER, OFS_LATE, OFS_TOO_MANY_HITS_FIELD};

	// All-ones value of a counter of the given width
	function automatic logic [23:0] cnt_max(input int w);
		return 24'((32'h1 << w) - 32'h1);
	endfunction

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	// Register port request, one cycle per strobe
	typedef struct packed {
		logic wr;
		logic rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} esc_bus_req_t;

	// End-of-transmit report, qualifiers valid while done is high
	typedef struct packed {
		logic done;
		logic underrun;
		logic [4:0] collisions;
		logic deferred;
		logic late_collision;
	} esc_tx_evt_t;

	// End-of-receive report, qualifiers valid while done is high
	typedef struct packed {
		logic done;
		logic [15:0] length;
		logic odd_bits;
		logic crc_bad;
		logic symbol_err;
		logic pause;
		logic copied;
	} esc_rx_evt_t;

endpackage

`default_nettype wire

// *** esc_stats.sv ***
// Purpose: Saturating, clear-on-read statistics counter bank for an Ethernet MAC.
// Assumes: Event reports are one-cycle pulses synchronous to clock_i.
// Notes:   Read data stands only in the cycle after the read strobe.
//
// Overview of operation
// - Reading a counter clears it to zero, or to one if an event arrives in the read cycle
// - Counters stick at all ones, never wrap
// - Receive counters count only with receive enabled
// - Counter writes need control bit 7 set
// - 16-bit count of good pause frames
// - 24-bit count of frames sent successfully
// - 16-bit count of sends after one collision
// - 16-bit count of sends after 2-15 collisions
// - 24-bit count of good frames copied
// - 8-bit count of whole-byte bad-CRC frames
// - Symbol error in whole-byte frame counts CRC
// - 8-bit count of odd-bit bad frames
// - 16-bit count of deferred first attempts
// - Deferral ignores collided or underrun frames
// - 8-bit count of collisions after slot time
// - Late collision also counts as collision
// - 8-bit count of sends abandoned at sixteen
`default_nettype none

module esc_stats
	import esc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire esc_bus_req_t bus_req_i,
	output logic [31:0] rdata_o,
	input wire esc_tx_evt_t tx_evt_i,
	input wire esc_rx_evt_t rx_evt_i,
	output logic rx_enable_o
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_reg; // First stage, read only by the second
	logic rst_n_reg; // Released reset used by all other logic

	// Assert at once, release two edges later to avoid a runt release
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_reg);

	// ----------------------------------------------------------------
	// Control and configuration registers
	// ----------------------------------------------------------------
	logic [31:0] ncr_reg; // Network control
	logic [31:0] ncfg_reg; // Network configuration
	logic stat_we; // Counter writes allowed
	logic rx_en; // Receive enabled
	logic big_frames; // Longer frame limit

	// Plain read-write words, unimplemented bits held at zero
	always_ff @(posedge clock_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			ncr_reg <= NCR_RESET;
			ncfg_reg <= NCFG_RESET;
		end
		else if (bus_req_i.wr)
		begin
			if (bus_req_i.addr == OFS_NET_CTRL)
				ncr_reg <= bus_req_i.wdata & NCR_MASK;
			if (bus_req_i.addr == OFS_NET_CFG)
				ncfg_reg <= bus_req_i.wdata & NCFG_MASK;
		end
	end

	assign stat_we = ncr_reg[NCR_STAT_WE_BIT];
	assign rx_en = ncr_reg[NCR_RX_EN_BIT];
	assign big_frames = ncfg_reg[NCFG_BIG_FRAME_BIT];
	assign rx_enable_o = rx_en;

	// ----------------------------------------------------------------
	// Frame classification
	// ----------------------------------------------------------------
	logic [15:0] len_limit; // Upper length bound in force
	logic rx_valid_len; // 64 up to the bound
	logic rx_on; // Receive report that may count
	logic rx_bad; // Check sequence or symbol trouble
	logic rx_good; // Valid length, no error of any kind
	logic tx_fin; // Transmit report without underrun
	logic tx_ok; // Frame actually went out

	// Oversize and undersize frames belong to other counters
	assign len_limit = big_frames ? FRAME_MAX_BIG : FRAME_MAX_LEN;
	assign rx_valid_len = (rx_evt_i.length >= FRAME_MIN_LEN) &&
		(rx_evt_i.length <= len_limit);

	// Receive reports are dropped while receive is off
	assign rx_on = rx_evt_i.done && rx_en;

	// A symbol error is folded in with a bad check sequence
	assign rx_bad = rx_evt_i.crc_bad || rx_evt_i.symbol_err;
	assign rx_good = rx_valid_len && !rx_bad;

	// An underrun frame counts nowhere else
	assign tx_fin = tx_evt_i.done && !tx_evt_i.underrun;
	assign tx_ok = tx_fin && (tx_evt_i.collisions < COL_EXCESS);

	// ----------------------------------------------------------------
	// Increment requests, one per counter
	// ----------------------------------------------------------------
	logic [NUM_CNT-1:0] inc; // Event seen this cycle

	always_comb
	begin
		inc = '0;
		// Good pause frames only
		inc[IDX_PAUSE] = rx_on && rx_evt_i.pause && rx_good;
		inc[IDX_TX_OK] = tx_ok;
		// Collision tally includes a late hit, so it lands here too
		inc[IDX_SCOL] = tx_ok && (tx_evt_i.collisions == COL_ONE);
		inc[IDX_MCOL] = tx_ok && (tx_evt_i.collisions >= COL_MULTI_MIN) &&
			(tx_evt_i.collisions <= COL_MULTI_MAX);
		// Kept frames must have matched and been copied out
		inc[IDX_RX_OK] = rx_on && rx_good && rx_evt_i.copied;
		// Whole-byte frames with bad check or symbol error
		inc[IDX_CRC] = rx_on && rx_valid_len && !rx_evt_i.odd_bits &&
			rx_bad;
		// Odd-bit frames, check taken over the truncated bytes
		inc[IDX_ALIGN] = rx_on && rx_valid_len && rx_evt_i.odd_bits &&
			rx_bad;
		// First attempt deferred, and no collision at all
		inc[IDX_DEFER] = tx_fin && tx_evt_i.deferred &&
			(tx_evt_i.collisions == COL_NONE);
		// Collision past the 512-bit slot time
		inc[IDX_LATE] = tx_fin && tx_evt_i.late_collision;
		// Abandoned after the sixteenth collision
		inc[IDX_TOO_MANY_HITS_FIELD] = tx_fin && (tx_evt_i.collisions >= COL_EXCESS);
	end

	// ----------------------------------------------------------------
	// Counter bank
	// ----------------------------------------------------------------
	logic [23:0] cnt_reg [NUM_CNT]; // Counter values, low bits used
	logic [NUM_CNT-1:0] rd_hit; // Read strobe on this counter
	logic [NUM_CNT-1:0] wr_hit; // Write strobe on this counter
	logic [NUM_CNT-1:0] room; // No access and not yet saturated

	genvar g;
	generate
		for (g = 0; g < NUM_CNT; g++)
		begin : g_cnt
			localparam logic [23:0] MAX = cnt_max(CNT_W[g]);

			assign rd_hit[g] = bus_req_i.rd && (bus_req_i.addr == CNT_OFS[g]);
			assign wr_hit[g] = bus_req_i.wr && (bus_req_i.addr == CNT_OFS[g]);
			assign room[g] = !rd_hit[g] && !wr_hit[g] && (cnt_reg[g] != MAX);

			// Gated write first, then clear-on-read, then counting
			always_ff @(posedge clock_i or negedge rst_n_reg)
			begin
				if (!rst_n_reg)
					cnt_reg[g] <= CNT_RESET;
				else if (wr_hit[g] && stat_we)
					cnt_reg[g] <= bus_req_i.wdata[23:0] & MAX;
				else if (rd_hit[g])
					// An event in the read cycle survives as a count of one
					cnt_reg[g] <= inc[g] ? 24'h000001 : CNT_RESET;
				else if (inc[g] && (cnt_reg[g] != MAX))
					// Saturate rather than wrap; unread events are lost
					cnt_reg[g] <= cnt_reg[g] + 24'h000001;
			end

			// Read leaves zero when nothing arrives alongside
			a_read_clears: assert property (
				rd_hit[g] && !inc[g] |=> cnt_reg[g] == CNT_RESET)
				else $error("counter not cleared by read");

			// Event in the read cycle is kept
			a_read_keeps_event: assert property (
				rd_hit[g] && inc[g] |=> cnt_reg[g] == 24'h000001)
				else $error("event lost in read cycle");

			// Saturated value holds through further events
			a_sat_holds: assert property (
				cnt_reg[g] == MAX && !rd_hit[g] && !(wr_hit[g] && stat_we)
				|=> cnt_reg[g] == MAX)
				else $error("counter left saturation");

			// Blocked write changes nothing
			a_write_blocked: assert property (
				wr_hit[g] && !stat_we && !inc[g] |=> $stable(cnt_reg[g]))
				else $error("write took effect while disabled");

			// Enabled write loads the masked data
			a_write_loads: assert property (
				wr_hit[g] && stat_we
				|=> cnt_reg[g] == ($past(bus_req_i.wdata[23:0]) & MAX))
				else $error("enabled write not loaded");

			// Each counted event adds exactly one
			a_count_step: assert property (
				inc[g] && room[g] |=> cnt_reg[g] == $past(cnt_reg[g]) + 24'h000001)
				else $error("counter step wrong");

			// Answer carries the value from before the clear
			a_read_answer: assert property (
				rd_hit[g] |=> rdata_o == {8'h00, $past(cnt_reg[g])})
				else $error("read answer not the pre-clear value");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	logic [31:0] rd_value; // Word selected by the address
	logic [31:0] rdata_reg; // Registered read answer

	// Unmapped addresses answer zero; upper bits always zero
	always_comb
	begin
		rd_value = 32'h00000000;
		if (bus_req_i.addr == OFS_NET_CTRL)
			rd_value = ncr_reg;
		if (bus_req_i.addr == OFS_NET_CFG)
			rd_value = ncfg_reg;
		for (int i = 0; i < NUM_CNT; i++)
		begin
			if (bus_req_i.addr == CNT_OFS[i])
				rd_value = {8'h00, cnt_reg[i]};
		end
	end

	// Value before the clear is returned; zero outside the answer cycle
	always_ff @(posedge clock_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			rdata_reg <= 32'h00000000;
		else if (bus_req_i.rd)
			rdata_reg <= rd_value;
		else
			rdata_reg <= 32'h00000000;
	end

	assign rdata_o = rdata_reg;

	// Answer stands one cycle only, so a late sampler sees zero
	a_answer_one_cycle: assert property (
		!bus_req_i.rd |=> rdata_o == 32'h00000000)
		else $error("read answer outlived its cycle");

	// ----------------------------------------------------------------
	// Event checks
	// ----------------------------------------------------------------
	// Kept-frame counter frozen while receive is off
	a_rx_gated: assert property (
		!rx_en && !rd_hit[IDX_RX_OK] && !wr_hit[IDX_RX_OK]
		|=> $stable(cnt_reg[IDX_RX_OK]))
		else $error("receive counter moved while disabled");

	// Good pause frame counts
	a_pause_good: assert property (
		rx_evt_i.done && rx_en && rx_evt_i.pause && rx_valid_len &&
		!rx_evt_i.crc_bad && !rx_evt_i.symbol_err && room[IDX_PAUSE]
		|=> cnt_reg[IDX_PAUSE] == $past(cnt_reg[IDX_PAUSE]) + 24'h000001)
		else $error("good pause frame not counted");

	// Underrun frames never count as sent
	a_tx_underrun: assert property (
		tx_evt_i.done && tx_evt_i.underrun && !rd_hit[IDX_TX_OK] &&
		!wr_hit[IDX_TX_OK] |=> $stable(cnt_reg[IDX_TX_OK]))
		else $error("underrun frame counted as sent");

	// Single collision send counts once
	a_single_col: assert property (
		tx_evt_i.done && !tx_evt_i.underrun && tx_evt_i.collisions == COL_ONE &&
		room[IDX_SCOL]
		|=> cnt_reg[IDX_SCOL] == $past(cnt_reg[IDX_SCOL]) + 24'h000001)
		else $error("single collision send not counted");

	// Fifteen collisions still a multi-collision send
	a_multi_col: assert property (
		tx_evt_i.done && !tx_evt_i.underrun &&
		tx_evt_i.collisions == COL_MULTI_MAX && room[IDX_MCOL]
		|=> cnt_reg[IDX_MCOL] == $past(cnt_reg[IDX_MCOL]) + 24'h000001)
		else $error("multi collision send not counted");

	// Uncopied frame is not a kept frame
	a_rx_copied: assert property (
		rx_evt_i.done && !rx_evt_i.copied && !rd_hit[IDX_RX_OK] &&
		!wr_hit[IDX_RX_OK] |=> $stable(cnt_reg[IDX_RX_OK]))
		else $error("uncopied frame counted");

	// Whole-byte symbol error lands in the CRC counter
	a_crc_symbol: assert property (
		rx_on && rx_valid_len && !rx_evt_i.odd_bits && rx_evt_i.symbol_err &&
		room[IDX_CRC]
		|=> cnt_reg[IDX_CRC] == $past(cnt_reg[IDX_CRC]) + 24'h000001)
		else $error("crc error not counted");

	// Odd-bit bad frame lands in the alignment counter
	a_align_count: assert property (
		rx_on && rx_valid_len && rx_evt_i.odd_bits && rx_evt_i.crc_bad &&
		room[IDX_ALIGN]
		|=> cnt_reg[IDX_ALIGN] == $past(cnt_reg[IDX_ALIGN]) + 24'h000001)
		else $error("alignment error not counted");

	// Collided frame is never a deferral
	a_defer_collided: assert property (
		tx_evt_i.done && tx_evt_i.collisions != COL_NONE && !rd_hit[IDX_DEFER] &&
		!wr_hit[IDX_DEFER] |=> $stable(cnt_reg[IDX_DEFER]))
		else $error("collided frame counted as deferred");

	// Late collision counts in both places
	a_late_both: assert property (
		tx_ok && tx_evt_i.late_collision && tx_evt_i.collisions == COL_ONE &&
		room[IDX_LATE] && room[IDX_SCOL]
		|=> cnt_reg[IDX_LATE] == $past(cnt_reg[IDX_LATE]) + 24'h000001 &&
		cnt_reg[IDX_SCOL] == $past(cnt_reg[IDX_SCOL]) + 24'h000001)
		else $error("late collision not counted twice");

	// Sixteenth collision abandons, never counted as sent
	a_excess_col: assert property (
		tx_fin && tx_evt_i.collisions == COL_EXCESS && room[IDX_TOO_MANY_HITS_FIELD] &&
		!rd_hit[IDX_TX_OK] && !wr_hit[IDX_TX_OK]
		|=> cnt_reg[IDX_TOO_MANY_HITS_FIELD] == $past(cnt_reg[IDX_TOO_MANY_HITS_FIELD]) + 24'h000001 &&
		$stable(cnt_reg[IDX_TX_OK]))
		else $error("excessive collision miscounted");

	// Pause, check and alignment counters frozen while receive is off
	a_rx_err_gated: assert property (
		!rx_en && !bus_req_i.rd && !bus_req_i.wr
		|=> $stable(cnt_reg[IDX_PAUSE]) && $stable(cnt_reg[IDX_CRC]) &&
		$stable(cnt_reg[IDX_ALIGN]))
		else $error("receive error counter moved while disabled");

	// Short pause frame is not a good one
	a_pause_short: assert property (
		rx_evt_i.done && rx_evt_i.length < FRAME_MIN_LEN && !rd_hit[IDX_PAUSE] &&
		!wr_hit[IDX_PAUSE] |=> $stable(cnt_reg[IDX_PAUSE]))
		else $error("short frame counted as pause");

	// Abandoned send is never a multi-collision send
	a_excess_not_multi: assert property (
		tx_evt_i.done && tx_evt_i.collisions >= COL_EXCESS && !rd_hit[IDX_MCOL] &&
		!wr_hit[IDX_MCOL] |=> $stable(cnt_reg[IDX_MCOL]))
		else $error("abandoned send counted as multi collision");

	// Underrun report leaves deferral, late and excessive counts alone
	a_underrun_silent: assert property (
		tx_evt_i.done && tx_evt_i.underrun && !bus_req_i.rd && !bus_req_i.wr
		|=> $stable(cnt_reg[IDX_DEFER]) && $stable(cnt_reg[IDX_LATE]) &&
		$stable(cnt_reg[IDX_TOO_MANY_HITS_FIELD]))
		else $error("underrun frame counted");

	// Deferred send with no collision counts once
	a_defer_count: assert property (
		tx_fin && tx_evt_i.deferred && tx_evt_i.collisions == COL_NONE &&
		room[IDX_DEFER]
		|=> cnt_reg[IDX_DEFER] == $past(cnt_reg[IDX_DEFER]) + 24'h000001)
		else $error("deferred send not counted");

endmodule

`default_nettype wire

// *** esc_mac_model.sv ***
// Purpose: Behavioural model of the MAC transmit and receive paths that report frame events.
// Assumes: One report per path per call, a one-cycle done pulse with its qualifiers.
// Notes:   Qualifiers show an inverted pattern once done drops after a pulse (all zero before the first), so stale values never match.
`default_nettype none

module esc_mac_model
	import esc_pkg::*;
(
	input wire logic clock_i,
	output var esc_tx_evt_t tx_evt_o,
	output var esc_rx_evt_t rx_evt_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Idle state at time zero
	// ----------------------------------------------------------------
	initial
	begin
		tx_evt_o = '0;
		rx_evt_o = '0;
	end

	// One transmit report; qualifiers garbled once done drops
	task automatic send_tx(input logic [4:0] col, input logic und, input logic def,
		input logic late);
		esc_tx_evt_t idle_evt;
		@(posedge clock_i);
		tx_evt_o <= '{done:1'b1, underrun:und, collisions:col, deferred:def, late_collision:late};
		@(posedge clock_i);
		idle_evt = ~tx_evt_o;
		idle_evt.done = 1'b0;
		tx_evt_o <= idle_evt;
	endtask

	// One receive report; same garbling after the pulse
	task automatic send_rx(input logic [15:0] len, input logic odd, input logic crc,
		input logic sym, input logic pse, input logic cpy);
		esc_rx_evt_t idle_evt;
		@(posedge clock_i);
		rx_evt_o <= '{done:1'b1, length:len, odd_bits:odd, crc_bad:crc, symbol_err:sym,
			pause:pse, copied:cpy};
		@(posedge clock_i);
		idle_evt = ~rx_evt_o;
		idle_evt.done = 1'b0;
		rx_evt_o <= idle_evt;
	endtask
endmodule

`default_nettype wire

// *** esc_stats_tb.sv ***
// Purpose: Self-checking bench for the statistics counter bank.
// Assumes: Register port strobes one cycle, read data sampled the cycle after the strobe.
// Notes:   Every counter is read after each classify case, so reads also prove clear-on-read.
`default_nettype none

module esc_stats_tb
	import esc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals and counters
	// ----------------------------------------------------------------
	localparam logic [9:0] B_PAU = 10'(1 << IDX_PAUSE);
	localparam logic [9:0] B_TXOK = 10'(1 << IDX_TX_OK);
	localparam logic [9:0] B_SCOL = 10'(1 << IDX_SCOL);
	localparam logic [9:0] B_MCOL = 10'(1 << IDX_MCOL);
	localparam logic [9:0] B_RXOK = 10'(1 << IDX_RX_OK);
	localparam logic [9:0] B_CRC = 10'(1 << IDX_CRC);
	localparam logic [9:0] B_ALN = 10'(1 << IDX_ALIGN);
	localparam logic [9:0] B_DEF = 10'(1 << IDX_DEFER);
	localparam logic [9:0] B_LATE = 10'(1 << IDX_LATE);
	localparam logic [9:0] B_EXC = 10'(1 << IDX_TOO_MANY_HITS_FIELD);
	logic clock_i;
	logic rst_n;
	esc_bus_req_t bus_req;
	logic [31:0] rdata;
	logic rx_en;
	esc_tx_evt_t tx_evt;
	esc_rx_evt_t rx_evt;
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;

	esc_stats u_dut (.clock_i(clock_i), .rst_n_i(rst_n), .bus_req_i(bus_req), .rdata_o(rdata),
		.tx_evt_i(tx_evt), .rx_evt_i(rx_evt), .rx_enable_o(rx_en));
	esc_mac_model u_mac (.clock_i(clock_i), .tx_evt_o(tx_evt), .rx_evt_o(rx_evt));

	// 200 MHz clock
	initial
	begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// Hang guard, far above the roughly 600 cycles the run needs
	always @(posedge clock_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Bus and compare helpers
	// ----------------------------------------------------------------
	task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
		@(posedge clock_i);
		bus_req <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
		@(posedge clock_i);
		bus_req <= '0;
	endtask

	// Answer stands only in the cycle after the strobe
	task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
		@(posedge clock_i);
		bus_req <= '{wr:1'b0, rd:1'b1, addr:a, wdata:32'h0};
		@(posedge clock_i);
		bus_req <= '0;
		#1;
		d = rdata;
	endtask

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// Reads all ten counters; each must hold exactly its mask bit
	task automatic check_bank(input logic [9:0] mask, input string msg);
		logic [31:0] d;
		for (int i = 0; i < NUM_CNT; i++)
		begin
			bus_read(CNT_OFS[i], d);
			check_val(d, {31'h0, mask[i]}, msg);
		end
	endtask

	task automatic tx_case(input logic [4:0] col, input logic und, input logic def,
		input logic late, input logic [9:0] mask);
		u_mac.send_tx(col, und, def, late);
		check_bank(mask, "tx classify");
	endtask

	task automatic rx_case(input logic [15:0] len, input logic odd, input logic crc,
		input logic sym, input logic pse, input logic [9:0] mask);
		u_mac.send_rx(len, odd, crc, sym, pse, 1'b1);
		check_bank(mask, "rx classify");
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Reset state, control words and an unmapped place
	task automatic test_reset;
		logic [31:0] d;
		check_val({31'h0, rx_en}, 32'h0, "rx enable at reset");
		bus_read(OFS_NET_CTRL, d);
		check_val(d, NCR_RESET, "control reset");
		bus_read(OFS_NET_CFG, d);
		check_val(d, NCFG_RESET, "config reset");
		check_bank(10'h000, "counters at reset");
		bus_write(32'hf802c100, 32'hffffffff);
		bus_read(32'hf802c100, d);
		check_val(d, 32'h0, "unmapped read");
	endtask

	// Transmit outcomes, including underrun, deferral and late hits
	task automatic test_tx;
		tx_case(5'd0, 1'b0, 1'b0, 1'b0, B_TXOK);
		tx_case(5'd1, 1'b0, 1'b0, 1'b0, B_TXOK | B_SCOL);
		tx_case(5'd2, 1'b0, 1'b0, 1'b0, B_TXOK | B_MCOL);
		tx_case(5'd15, 1'b0, 1'b0, 1'b0, B_TXOK | B_MCOL);
		tx_case(5'd16, 1'b0, 1'b0, 1'b0, B_EXC);
		tx_case(5'd1, 1'b1, 1'b1, 1'b0, 10'h000);
		tx_case(5'd0, 1'b0, 1'b1, 1'b0, B_TXOK | B_DEF);
		tx_case(5'd3, 1'b0, 1'b1, 1'b0, B_TXOK | B_MCOL);
		tx_case(5'd1, 1'b0, 1'b0, 1'b1, B_TXOK | B_SCOL | B_LATE);
	endtask

	// Receive classes at the length edges, then with big frames and disabled
	task automatic test_rx;
		bus_write(OFS_NET_CTRL, 32'h4);
		#1;
		check_val({31'h0, rx_en}, 32'h1, "rx enable set");
		rx_case(16'd64, 1'b0, 1'b0, 1'b0, 1'b1, B_PAU | B_RXOK);
		rx_case(16'd1518, 1'b0, 1'b0, 1'b0, 1'b0, B_RXOK);
		rx_case(16'd63, 1'b0, 1'b0, 1'b0, 1'b1, 10'h000);
		rx_case(16'd1519, 1'b0, 1'b0, 1'b0, 1'b1, 10'h000);
		rx_case(16'd1518, 1'b0, 1'b1, 1'b0, 1'b0, B_CRC);
		rx_case(16'd64, 1'b0, 1'b0, 1'b1, 1'b0, B_CRC);
		rx_case(16'd100, 1'b1, 1'b1, 1'b0, 1'b0, B_ALN);
		rx_case(16'd100, 1'b1, 1'b0, 1'b1, 1'b0, B_ALN);
		rx_case(16'd1519, 1'b0, 1'b1, 1'b0, 1'b0, 10'h000);
		bus_write(OFS_NET_CFG, 32'h100);
		rx_case(16'd1536, 1'b0, 1'b0, 1'b0, 1'b1, B_PAU | B_RXOK);
		rx_case(16'd1536, 1'b0, 1'b1, 1'b0, 1'b0, B_CRC);
		rx_case(16'd1537, 1'b0, 1'b0, 1'b0, 1'b1, 10'h000);
		bus_write(OFS_NET_CTRL, 32'h0);
		rx_case(16'd64, 1'b0, 1'b1, 1'b0, 1'b1, 10'h000);
	endtask

	// Write gating, width masking, saturation and clear after saturation
	task automatic test_write_sat;
		logic [31:0] d;
		bus_write(OFS_NET_CTRL, 32'h4);
		bus_write(OFS_CRC, 32'h55);
		bus_read(OFS_CRC, d);
		check_val(d, 32'h0, "write without enable");
		bus_write(OFS_NET_CTRL, 32'h84);
		bus_read(OFS_NET_CTRL, d);
		check_val(d, 32'h84, "control readback");
		bus_write(OFS_CRC, 32'h1fe);
		u_mac.send_rx(16'd64, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		u_mac.send_rx(16'd64, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		bus_read(OFS_CRC, d);
		check_val(d, 32'hff, "8-bit saturation");
		bus_write(OFS_TX_OK, 32'hfffffe);
		u_mac.send_tx(5'd0, 1'b0, 1'b0, 1'b0);
		u_mac.send_tx(5'd0, 1'b0, 1'b0, 1'b0);
		bus_read(OFS_TX_OK, d);
		check_val(d, 32'h00ffffff, "24-bit saturation");
		// The reads above cleared both saturated counters; all ten must read zero here
		check_bank(10'h000, "clear after saturation");
	endtask

	// Event beside a read or an enabled write, and the answer's single cycle
	task automatic test_same_cycle;
		logic [31:0] d;
		fork
			u_mac.send_tx(5'd0, 1'b0, 1'b0, 1'b0);
			bus_read(OFS_TX_OK, d);
		join
		check_val(d, 32'h0, "read beside event");
		bus_read(OFS_TX_OK, d);
		check_val(d, 32'h1, "event beside read kept");
		@(posedge clock_i);
		#1;
		check_val(rdata, 32'h0, "answer after its cycle");
		fork
			u_mac.send_tx(5'd0, 1'b0, 1'b0, 1'b0);
			bus_write(OFS_TX_OK, 32'h10);
		join
		bus_read(OFS_TX_OK, d);
		check_val(d, 32'h10, "write beside event");
	endtask

	// ----------------------------------------------------------------
	// Verdict and main sequence
	// ----------------------------------------------------------------
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		rst_n = 1'b0;
		bus_req = '0;
		repeat (16) @(posedge clock_i);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock_i);
		test_reset();
		test_tx();
		test_rx();
		test_write_sat();
		test_same_cycle();
		print_verdict();
	end
endmodule

`default_nettype wire
